/* co2_calibration_command_parser_test.sv */
// self-checking bench for both ends of the co2 calibration command link
`timescale 1ns/1ps
module co2_calibration_command_parser_test
  import co2cal_pkg::*;
;
  typedef struct {string c; string r;} co2cal_row_t;
  //============================================================================
  // signals
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [23:0] zero_point, known_gas, bg_auto, fresh_air;
  logic az_enable, az_start;
  logic zero_load, known_gas_load, bg_auto_load, fresh_air_load, hresp;
  logic [3:0] loads_seen = 4'h0;
  logic [16:0] az_initial, az_regular, comp_value;
  logic start_seen = 1'b0;
  logic [31:0] r;
  int n_mismatch = 0;
  int n_checks = 0;
  // command lines beside the replies they should give
  co2cal_row_t rows[12] = '{'{"S 100", "S 00100"}, '{"s", "s 00100"},
    '{"u 32767", "u 32767"}, '{"X 2000", "X 33000"}, '{"P 8 1", "p 8 1"},
    '{"P 9 144", "p 9 144"}, '{"P 10 7", "p 10 7"}, '{"P 11 208", "p 11 208"},
    '{"@ 0", "@ 0"}, '{"@", "@ 0"}, '{"@ 2.5 0.7", "@ 2.5 0.7"},
    '{"@", "@ 0002.5 0000.7"}};
  //============================================================================
  // design
  co2cal_link_if u_co2cal_link_if();
  co2cal_device u_co2cal_device (.hclk(hclk), .hresetn(hresetn), .link(u_co2cal_link_if),
    .zero_point(zero_point), .zero_load(zero_load), .known_gas(known_gas),
    .known_gas_load(known_gas_load), .zero_calc(16'h80E8), .bg_auto(bg_auto),
    .bg_auto_load(bg_auto_load), .fresh_air(fresh_air),
    .fresh_air_load(fresh_air_load), .az_enable(az_enable), .az_initial(az_initial),
    .az_regular(az_regular), .az_start(az_start), .comp_value(comp_value));
  co2cal_host u_co2cal_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(u_co2cal_link_if));
  co2cal_link_checker u_co2cal_link_checker (.hclk(hclk), .hresetn(hresetn),
    .h2d_valid(u_co2cal_link_if.h2d_valid), .h2d_ready(u_co2cal_link_if.h2d_ready),
    .h2d_data(u_co2cal_link_if.h2d_data), .d2h_valid(u_co2cal_link_if.d2h_valid),
    .d2h_ready(u_co2cal_link_if.d2h_ready), .d2h_data(u_co2cal_link_if.d2h_data));
  //============================================================================
  // clock, start pulse catcher, watchdog
  always #2 hclk = ~hclk;
  always @(posedge hclk) begin
    if (az_start === 1'b1) start_seen <= 1'b1;
    if (hresetn) begin
      loads_seen <= loads_seen | {zero_load, known_gas_load, bg_auto_load, fresh_air_load};
    end
  end
  initial begin
    repeat (60000) @(posedge hclk);
    n_mismatch++;
    print_verdict();
  end
  //============================================================================
  // tasks
  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // one single-word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // wait for transmitter idle, then queue one byte or the terminator
  task automatic put(input logic [31:0] d);
    logic [31:0] q;
    do ahb(1'b0, REG_STATUS, 32'h0, q); while (q[0] !== 1'b0);
    ahb(1'b1, REG_TXDATA, d, q);
  endtask
  task automatic put_str(input string s);
    foreach (s[i]) put({24'h0, s[i]});
  endtask
  task automatic send(input string s);
    put_str(s);
    put(32'h100);
  endtask
  // collect reply bytes with a bounded poll each
  task automatic reply(input string s);
    string t;
    logic [31:0] q;
    int k;
    t = {s, "\r\n"};
    foreach (t[i]) begin
      k = 0;
      do begin
        ahb(1'b0, REG_RXDATA, 32'h0, q);
        k++;
      end while (q[8] !== 1'b1 && k < 500);
      chk({24'h0, q[7:0]}, {24'h0, t[i]});
    end
  endtask
  //============================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      send(rows[i].c);
      reply(rows[i].r);
    end
    chk(comp_value, 17'h00064);
    chk(loads_seen, 4'hF);
    chk(hresp, 1'b0);
    chk(zero_point, 24'h04FFF6);
    chk(known_gas, 24'h004E20);
    chk(bg_auto, 24'h000FA0);
    chk(fresh_air, 24'h004E20);
    chk(az_enable, 1'b1);
    chk(az_initial, 17'h00019);
    chk(az_regular, 17'h00007);
    // nothing happens until the terminator arrives
    put_str("S 5");
    repeat (20) @(posedge hclk);
    chk(comp_value, 17'h00064);
    put(32'h100);
    reply("S 00005");
    chk(comp_value, 17'h00005);
    // malformed line dropped, setting kept
    send("S 9z");
    send("s");
    reply("s 00005");
    send("65222");
    repeat (10) @(posedge hclk);
    chk(start_seen, 1'b1);
    // split register and an unmapped word
    ahb(1'b1, REG_SPLIT, 32'h190, r);
    ahb(1'b0, REG_SPLIT, 32'h0, r);
    chk(r, 32'h00010090);
    ahb(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
    // second reset restores defaults
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(comp_value, 17'h02000);
    chk(az_enable, 1'b1);
    chk(az_initial, AZ_INIT_DEF);
    chk(az_regular, AZ_REG_DEF);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    print_verdict();
  end
endmodule // co2_calibration_command_parser_test

/* co2cal_dec5.sv */
// five digit decimal ascii formatter
`timescale 1ns/1ps
module co2cal_dec5
  import co2cal_pkg::*;
(
  // value in
  input wire logic [16:0] value,
  // ascii digits, most significant first
  output logic [39:0] digits
);
  // one digit per decade
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      digits[8*k +: 8] = ASC_ZERO + 8'((value / (17'h1 * (10 ** k))) % 10);
    end
  end
endmodule // co2cal_dec5

/* co2cal_device.sv */
// sensor end: command line parser, settings and responder
`timescale 1ns/1ps
module co2cal_device
  import co2cal_pkg::*;
#(
  parameter bit WIDE_RANGE = 1'b0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link
  co2cal_link_if.dev link,
  // zero point
  output logic [23:0] zero_point,
  output logic zero_load,
  output logic [23:0] known_gas,
  output logic known_gas_load,
  input wire logic [15:0] zero_calc,
  // background levels
  output logic [23:0] bg_auto,
  output logic bg_auto_load,
  output logic [23:0] fresh_air,
  output logic fresh_air_load,
  // auto-zero
  output logic az_enable,
  output logic [16:0] az_initial,
  output logic [16:0] az_regular,
  output logic az_start,
  // compensation
  output logic [16:0] comp_value
);
  //============================================================================
  // helpers
  function automatic logic [23:0] scale(input logic [16:0] v, input logic [6:0] m);
    scale = 24'({7'h00, v} * {17'h00000, m});
  endfunction

  function automatic logic [7:0] dig(input logic [39:0] d, input logic [4:0] i);
    dig = d[39 - 8 * i -: 8];
  endfunction

  //============================================================================
  // state
  co2cal_state_t state;
  co2cal_txkind_t tx_kind;
  logic [7:0] line_buf [BUF_DEPTH];
  logic [4:0] pos;
  logic [4:0] echo_len;
  logic [4:0] tx_len;
  logic [4:0] tx_idx;
  logic [7:0] cmd;
  logic [1:0] fi;
  logic [16:0] val [2];
  logic [2:0] nd [2];
  logic dt [2];
  logic [1:0] fr [2];
  logic bad;
  logic cr_seen;
  logic [7:0] resp_char;
  logic [16:0] resp_val;
  logic [7:0] bg_hi;
  logic [7:0] fa_hi;

  //============================================================================
  // byte classification
  wire [7:0] b = link.h2d_data;
  wire rx_fire = link.h2d_valid && link.h2d_ready;
  wire is_digit = (b >= ASC_ZERO) && (b <= ASC_NINE);
  wire first = (pos == 5'h00);
  wire line_end = rx_fire && (b == ASC_LF) && cr_seen; // [R01]
  wire cr_first = (b == ASC_CR) && !cr_seen;
  wire stored = rx_fire && !cr_first && !line_end;
  wire cmd_digit = (cmd >= ASC_ZERO) && (cmd <= ASC_NINE);
  wire [1:0] tgt = (first || ((fi == 2'h0) && cmd_digit)) ? 2'h1 : fi; // digit-led line, one field
  wire fsel = (tgt == 2'h2);
  wire [23:0] acc_next = 24'({7'h00, val[fsel]} * DEC_BASE) + {20'h00000, b[3:0]};
  wire acc_over = acc_next > ACC_MAX;
  wire [6:0] mult = WIDE_RANGE ? MULT_WIDE : MULT_STD; // [R16]

  //============================================================================
  // line decode at terminator
  wire num1_ok = (fi == 2'h1) && (nd[0] != 3'h0) && !dt[0] && !bad; // [R17]
  wire two_int = (fi == 2'h2) && (nd[0] != 3'h0) && (nd[1] != 3'h0) && !dt[0] && !dt[1] && !bad;
  wire ivl_ok = (fi == 2'h2) && !bad && dt[0] && dt[1] && (fr[0] == 2'h1) && (fr[1] == 2'h1)
                && (nd[0] >= 3'h2) && (nd[1] >= 3'h2); // [R09]
  wire bare = (fi == 2'h0) && !bad && (pos == 5'h01);
  wire p_idx_ok = (val[0] >= IDX_BG_HI) && (val[0] <= IDX_FA_LO);
  wire do_u = (cmd == ASC_LU) && num1_ok;
  wire do_x = (cmd == ASC_X) && num1_ok;
  wire do_s = (cmd == ASC_S) && num1_ok && (val[0] <= COMP_MAX);
  wire do_sq = (cmd == ASC_LS) && bare;
  wire do_p = (cmd == ASC_P) && two_int && p_idx_ok && (val[1] <= BYTE_MAX);
  wire do_iset = (cmd == ASC_AT) && ivl_ok;
  wire do_ioff = (cmd == ASC_AT) && num1_ok && (val[0] == 17'h00000);
  wire do_irep = (cmd == ASC_AT) && bare;
  wire do_trig = cmd_digit && (fi == 2'h0) && !dt[0] && !bad && (val[0] == TRIG_CODE); // [R12]
  wire reply = do_u || do_x || do_s || do_sq || do_p || do_iset || do_ioff || do_irep;

  //============================================================================
  // response byte selection
  logic [39:0] da;
  logic [39:0] db;
  wire [16:0] da_src = (tx_kind == TK_IVL) ? az_initial : resp_val;
  co2cal_dec5 u_dec_a (.value(da_src), .digits(da));
  co2cal_dec5 u_dec_b (.value(az_regular), .digits(db));

  wire [7:0] echo_first = (line_buf[0] == ASC_P) ? (line_buf[0] | ASC_CASE) : line_buf[0];
  wire [7:0] echo_b = (tx_idx < echo_len) ? ((tx_idx == 5'h00) ? echo_first
                      : line_buf[tx_idx[3:0]]) : ((tx_idx == echo_len) ? ASC_CR : ASC_LF);
  wire [7:0] num_b = (tx_idx == 5'h00) ? resp_char : (tx_idx == 5'h01) ? ASC_SP
                     : (tx_idx <= 5'h06) ? dig(da, 5'(tx_idx - 5'h02))
                     : (tx_idx == 5'h07) ? ASC_CR : ASC_LF; // [R18]
  wire [7:0] ivl_b = (tx_idx == 5'h00) ? ASC_AT : (tx_idx == 5'h01) ? ASC_SP
                     : (tx_idx <= 5'h05) ? dig(da, 5'(tx_idx - 5'h02))
                     : (tx_idx == 5'h06) ? ASC_DOT : (tx_idx == 5'h07) ? dig(da, 5'h04)
                     : (tx_idx == 5'h08) ? ASC_SP
                     : (tx_idx <= 5'h0C) ? dig(db, 5'(tx_idx - 5'h09))
                     : (tx_idx == 5'h0D) ? ASC_DOT : (tx_idx == 5'h0E) ? dig(db, 5'h04)
                     : (tx_idx == 5'h0F) ? ASC_CR : ASC_LF;
  wire [7:0] off_b = (tx_idx == 5'h00) ? ASC_AT : (tx_idx == 5'h01) ? ASC_SP
                     : (tx_idx == 5'h02) ? ASC_ZERO : (tx_idx == 5'h03) ? ASC_CR : ASC_LF;
  wire [7:0] tx_byte = (tx_kind == TK_ECHO) ? echo_b : (tx_kind == TK_NUM) ? num_b
                       : (tx_kind == TK_IVL) ? ivl_b : off_b;
  wire tx_free = !link.d2h_valid || link.d2h_ready;

  //============================================================================
  // raw line store, kept for echoes
  always_ff @(posedge hclk) begin
    if (stored && (pos != BUF_LAST)) begin
      line_buf[pos[3:0]] <= b;
    end
  end

  //============================================================================
  // byte parser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos <= 5'h00;
      fi <= 2'h0;
      cmd <= 8'h00;
      bad <= 1'b0;
      cr_seen <= 1'b0;
      echo_len <= 5'h00;
      for (int k = 0; k < 2; k++) begin
        val[k] <= 17'h00000;
        nd[k] <= 3'h0;
        dt[k] <= 1'b0;
        fr[k] <= 2'h0;
      end
    end else if (line_end) begin
      echo_len <= pos;
      pos <= 5'h00;
      fi <= 2'h0;
      bad <= 1'b0;
      cr_seen <= 1'b0;
      for (int k = 0; k < 2; k++) begin
        val[k] <= 17'h00000;
        nd[k] <= 3'h0;
        dt[k] <= 1'b0;
        fr[k] <= 2'h0;
      end
    end else if (rx_fire && cr_first) begin
      cr_seen <= 1'b1;
    end else if (rx_fire) begin
      cr_seen <= 1'b0;
      if (cr_seen || (pos == BUF_LAST)) begin
        bad <= 1'b1; // [R01]
      end
      if (pos != BUF_LAST) begin
        pos <= pos + 5'h01;
      end
      if (first) begin
        cmd <= b;
      end
      if (is_digit && (tgt != 2'h0) && !acc_over) begin
        val[fsel] <= acc_next[16:0];
        nd[fsel] <= (nd[fsel] == 3'h7) ? nd[fsel] : nd[fsel] + 3'h1;
        fr[fsel] <= (dt[fsel] && (fr[fsel] != 2'h3)) ? fr[fsel] + 2'h1 : fr[fsel];
      end else if (is_digit) begin
        bad <= 1'b1; // [R17]
      end else if ((b == ASC_SP) && !first) begin
        if (fi == 2'h2) begin
          bad <= 1'b1;
        end else begin
          fi <= fi + 2'h1;
        end
      end else if ((b == ASC_DOT) && (fi != 2'h0) && !dt[fsel]) begin
        dt[fsel] <= 1'b1;
      end else if (!first) begin
        bad <= 1'b1; // [R17]
      end
    end
  end

  //============================================================================
  // command execution and settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_point <= 24'h000000;
      known_gas <= 24'h000000;
      bg_auto <= 24'h000000;
      fresh_air <= 24'h000000;
      bg_hi <= 8'h00;
      fa_hi <= 8'h00;
      zero_load <= 1'b0;
      known_gas_load <= 1'b0;
      bg_auto_load <= 1'b0;
      fresh_air_load <= 1'b0;
      az_start <= 1'b0;
      az_enable <= 1'b1;
      az_initial <= AZ_INIT_DEF;
      az_regular <= AZ_REG_DEF;
      comp_value <= COMP_DEF;
    end else begin
      zero_load <= line_end && do_u;
      known_gas_load <= line_end && do_x;
      bg_auto_load <= line_end && do_p && (val[0] == IDX_BG_LO);
      fresh_air_load <= line_end && do_p && (val[0] == IDX_FA_LO);
      az_start <= line_end && do_trig; // [R12]
      if (line_end && do_u) begin
        zero_point <= scale(val[0], mult); // [R02] [R03]
      end
      if (line_end && do_x) begin
        known_gas <= scale(val[0], mult); // [R04] [R03]
      end
      if (line_end && do_p) begin
        if (val[0] == IDX_BG_HI) bg_hi <= val[1][7:0]; // [R05]
        if (val[0] == IDX_BG_LO) bg_auto <= scale({1'b0, bg_hi, val[1][7:0]}, mult); // [R05]
        if (val[0] == IDX_FA_HI) fa_hi <= val[1][7:0]; // [R07]
        if (val[0] == IDX_FA_LO) fresh_air <= scale({1'b0, fa_hi, val[1][7:0]}, mult); // [R07]
      end
      if (line_end && do_iset) begin
        az_enable <= 1'b1; // [R08]
        az_initial <= val[0];
        az_regular <= val[1];
      end
      if (line_end && do_ioff) begin
        az_enable <= 1'b0; // [R11]
      end
      if (line_end && do_s) begin
        comp_value <= val[0]; // [R14]
      end
    end
  end

  //============================================================================
  // responder
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_RX;
      tx_kind <= TK_ECHO;
      tx_len <= 5'h00;
      tx_idx <= 5'h00;
      resp_char <= 8'h00;
      resp_val <= 17'h00000;
      link.h2d_ready <= 1'b0;
      link.d2h_valid <= 1'b0;
      link.d2h_data <= 8'h00;
    end else begin
      unique case (state)
        ST_RX: begin
          link.h2d_ready <= !(line_end && reply);
          if (line_end && reply) begin
            state <= ST_EXEC;
            tx_idx <= 5'h00;
            resp_char <= cmd;
            resp_val <= do_sq ? comp_value : val[0]; // [R15]
            if (do_p || do_iset || do_ioff) begin
              tx_kind <= TK_ECHO; // [R10]
              tx_len <= pos + LEN_TERM;
            end else if (do_irep) begin
              tx_kind <= az_enable ? TK_IVL : TK_OFF; // [R13]
              tx_len <= az_enable ? LEN_IVL : LEN_OFF;
            end else begin
              tx_kind <= TK_NUM; // [R18]
              tx_len <= LEN_NUM;
            end
          end
        end
        ST_EXEC: begin
          state <= ST_TX;
          if (resp_char == ASC_X) begin
            resp_val <= {1'b0, zero_calc}; // [R04]
          end
        end
        ST_TX: begin
          if (tx_free) begin
            if (tx_idx < tx_len) begin
              link.d2h_valid <= 1'b1;
              link.d2h_data <= tx_byte;
              tx_idx <= tx_idx + 5'h01;
            end else begin
              link.d2h_valid <= 1'b0;
              link.h2d_ready <= 1'b1;
              state <= ST_RX;
            end
          end
        end
        default: begin
          state <= ST_RX;
        end
      endcase
    end
  end
endmodule // co2cal_device

/* co2cal_host.sv */
// host end: ahb-lite register front for sending command lines and reading replies
`timescale 1ns/1ps
module co2cal_host
  import co2cal_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // link
  co2cal_link_if.host link
);
  //============================================================================
  // state
  logic wr_pend;
  logic [7:0] wr_addr;
  logic lf_pend;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic [15:0] split_conc;

  //============================================================================
  // address phase decode
  wire addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire rd_take = addr_take && !hwrite;
  wire rd_rx = rd_take && (haddr[7:0] == REG_RXDATA);
  wire wr_tx = wr_pend && (wr_addr == REG_TXDATA) && !link.h2d_valid;
  wire wr_split = wr_pend && (wr_addr == REG_SPLIT);
  wire rx_fire = link.d2h_valid && link.d2h_ready;
  wire tx_fire = link.h2d_valid && link.h2d_ready;
  wire next_rx_valid = rx_fire || (rx_valid && !rd_rx); // set wins over clear
  wire [31:0] status_word = {30'h00000000, rx_valid, link.h2d_valid};
  wire [31:0] rx_word = {23'h000000, rx_valid, rx_byte};
  wire [31:0] split_word = {8'h00, split_conc[15:8], 8'h00, split_conc[7:0]}; // [R06]
  wire [31:0] rd_word = (haddr[7:0] == REG_STATUS) ? status_word
                        : (haddr[7:0] == REG_RXDATA) ? rx_word
                        : (haddr[7:0] == REG_SPLIT) ? split_word : 32'h00000000;

  //============================================================================
  // bus slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      split_conc <= 16'h0000;
    end else begin
      wr_pend <= addr_take && hwrite;
      wr_addr <= haddr[7:0];
      if (rd_take) begin
        hrdata <= rd_word;
      end
      if (wr_split) begin
        split_conc <= hwdata[15:0];
      end
    end
  end

  //============================================================================
  // link transmit, terminator pair sent on request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.h2d_valid <= 1'b0;
      link.h2d_data <= 8'h00;
      lf_pend <= 1'b0;
    end else if (tx_fire) begin
      if (lf_pend) begin
        link.h2d_data <= ASC_LF; // [R01]
        lf_pend <= 1'b0;
      end else begin
        link.h2d_valid <= 1'b0;
      end
    end else if (wr_tx) begin
      link.h2d_valid <= 1'b1;
      link.h2d_data <= hwdata[TX_EOL_BIT] ? ASC_CR : hwdata[7:0]; // [R01]
      lf_pend <= hwdata[TX_EOL_BIT];
    end
  end

  //============================================================================
  // link receive, single holding byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      link.d2h_ready <= 1'b0;
    end else begin
      rx_valid <= next_rx_valid;
      link.d2h_ready <= !next_rx_valid;
      if (rx_fire) begin
        rx_byte <= link.d2h_data;
      end
    end
  end
endmodule // co2cal_host

/* co2cal_link_checker.sv */
// concurrent checks on the byte link between host end and sensor end
`timescale 1ns/1ps
module co2cal_link_checker
  import co2cal_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // host to device
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire logic [7:0] h2d_data,
  // device to host
  input wire logic d2h_valid,
  input wire logic d2h_ready,
  input wire logic [7:0] d2h_data
);
  //============================================================================
  // shared clocking
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // line terminator taken, and reply handshakes
  wire lf_take = h2d_valid && h2d_ready && h2d_data == ASC_LF;
  wire d2h_take = d2h_valid && d2h_ready;
  //============================================================================
  // assertions
  AST_H2D_HOLD: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("host byte changed before acceptance");
  AST_D2H_HOLD: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
    else $error("reply byte changed before acceptance");
  AST_REPLY_START: assert property (lf_take ##1 !h2d_ready |-> ##1 !d2h_valid ##1 d2h_valid)
    else $error("reply did not start three cycles after terminator");
  AST_REFUSE_IN_REPLY: assert property (d2h_valid |-> !h2d_ready)
    else $error("device accepts bytes while replying");
  AST_READY_AFTER_RESET: assert property ($rose(hresetn) |-> !h2d_ready ##1 h2d_ready)
    else $error("device ready timing after reset wrong");
  AST_CR_THEN_LF: assert property (d2h_take && d2h_data == ASC_CR |=> d2h_valid && d2h_data == ASC_LF)
    else $error("carriage return not followed by line feed");
  AST_LF_ENDS: assert property (d2h_take && d2h_data == ASC_LF |=> !d2h_valid ##1 h2d_ready)
    else $error("reply did not end after line feed");
  AST_PARAM_LOWER: assert property ($rose(d2h_valid) |-> d2h_data != ASC_P)
    else $error("parameter echo not lowercase");
endmodule // co2cal_link_checker

/* co2cal_link_if.sv */
// byte link between host controller and sensor command parser
`timescale 1ns/1ps
interface co2cal_link_if;
  logic h2d_valid;
  logic h2d_ready;
  logic [7:0] h2d_data;
  logic d2h_valid;
  logic d2h_ready;
  logic [7:0] d2h_data;
  modport dev (input h2d_valid, h2d_data, d2h_ready, output h2d_ready, d2h_valid, d2h_data);
  modport host (output h2d_valid, h2d_data, d2h_ready, input h2d_ready, d2h_valid, d2h_data);
endinterface

/* co2cal_pkg.sv */
// constants and types shared by both ends of the co2 calibration command link
//==============================================================================
// Functional notes
// [R01] lines end with carriage return, line feed
// [R02] u command forces zero point, echoes value
// [R03] concentration arguments scaled by value multiplier
// [R04] X command zeroes in known gas
// [R05] P 8/9 load background, echoed lowercase
// [R06] host splits concentration, high byte first
// [R07] P 10/11 load fresh-air level, echoed
// [R08] interval command carries initial, regular days
// [R09] host sends intervals with one decimal
// [R10] interval setting echoed exactly as received
// [R11] single zero argument disables auto-zero
// [R12] line 65222 starts auto-zero at once
// [R13] bare interval command reports configuration
// [R14] S command stores compensation, echoes it
// [R15] s command returns stored compensation
// [R16] multiplier 10 standard, 100 wide range
// [R17] malformed lines discarded, settings kept
// [R18] numbers sent as five padded digits
package co2cal_pkg;
  //============================================================================
  // ascii codes
  localparam logic [7:0] ASC_CR = 8'h0D;
  localparam logic [7:0] ASC_LF = 8'h0A;
  localparam logic [7:0] ASC_SP = 8'h20;
  localparam logic [7:0] ASC_DOT = 8'h2E;
  localparam logic [7:0] ASC_ZERO = 8'h30;
  localparam logic [7:0] ASC_NINE = 8'h39;
  localparam logic [7:0] ASC_AT = 8'h40;
  localparam logic [7:0] ASC_P = 8'h50;
  localparam logic [7:0] ASC_S = 8'h53;
  localparam logic [7:0] ASC_X = 8'h58;
  localparam logic [7:0] ASC_LS = 8'h73;
  localparam logic [7:0] ASC_LU = 8'h75;
  localparam logic [7:0] ASC_CASE = 8'h20;
  //============================================================================
  // line buffer and values
  localparam int BUF_DEPTH = 16;
  localparam logic [4:0] BUF_LAST = 5'h10;
  localparam logic [23:0] DEC_BASE = 24'h00000A;
  localparam logic [23:0] ACC_MAX = 24'h01FFFF;
  localparam logic [16:0] COMP_DEF = 17'h02000;
  localparam logic [16:0] COMP_MAX = 17'h10000;
  localparam logic [16:0] TRIG_CODE = 17'h0FEC6;
  localparam logic [16:0] BYTE_MAX = 17'h000FF;
  localparam logic [16:0] IDX_BG_HI = 17'h00008;
  localparam logic [16:0] IDX_BG_LO = 17'h00009;
  localparam logic [16:0] IDX_FA_HI = 17'h0000A;
  localparam logic [16:0] IDX_FA_LO = 17'h0000B;
  localparam logic [16:0] AZ_INIT_DEF = 17'h0000A;
  localparam logic [16:0] AZ_REG_DEF = 17'h00050;
  localparam logic [6:0] MULT_STD = 7'h0A;
  localparam logic [6:0] MULT_WIDE = 7'h64;
  //============================================================================
  // response lengths in bytes
  localparam logic [4:0] LEN_NUM = 5'h09;
  localparam logic [4:0] LEN_IVL = 5'h11;
  localparam logic [4:0] LEN_OFF = 5'h05;
  localparam logic [4:0] LEN_TERM = 5'h02;
  //============================================================================
  // host register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_TXDATA = 8'h04;
  localparam logic [7:0] REG_RXDATA = 8'h08;
  localparam logic [7:0] REG_SPLIT = 8'h0C;
  localparam int TX_EOL_BIT = 8;
  localparam int RX_VALID_BIT = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  //============================================================================
  // states
  typedef enum logic [1:0] {ST_RX = 2'b00, ST_EXEC = 2'b01, ST_TX = 2'b10} co2cal_state_t;
  typedef enum logic [1:0] {
    TK_ECHO = 2'b00, TK_NUM = 2'b01, TK_IVL = 2'b10, TK_OFF = 2'b11
  } co2cal_txkind_t;
endpackage
